// file: hw/sem_regs.svh
// Overview of operation
// - Frame error raises an event only while its enable, bit 12, is set.
// - Busy status raises an event only while its enable, bit 11, is set.
// - Transmit underrun raises an event only while enable bit 8 is set.
// - Shifter empty raises an event only while enable bit 7 is set.
// - Receive overflow raises an event only while enable bit 6 is set.
// - Receive buffer empty raises an event only while enable bit 5 is set.
// - Transmit buffer empty raises an event only while enable bit 3 is set.
// - Transmit buffer full raises an event only while enable bit 1 is set.
// - Receive buffer full raises an event only while enable bit 0 is set.
// - Receive watermark fires when level is at most the receive count, if enabled.
// - Transmit watermark fires when level equals the transmit count, if enabled.
// - Receive level sits at bits 13 to 8 of the high mask register.
// - Transmit level sits at bits 5 to 0 of the high mask register.
// - A level above the buffer depth never matches.
// - Upper level bits exist only for deep enough buffers.
// - Serial clock is bus clock over two times the sum of divider and one.
// - Overflow sets when a word completes while the receive buffer is full.
// - Receive count is six bits at 13 to 8 of the high status register.
// - Shifter empty reads one only with no current or pending transfer.
`ifndef SEM_REGS_SVH
`define SEM_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SEM_OFS_ENABLE_LOW 12'h000
`define SEM_OFS_WATERMARK_HIGH 12'h004
`define SEM_OFS_BAUD_DIVIDER 12'h008
`define SEM_OFS_STATUS_LOW 12'h00C
`define SEM_OFS_STATUS_HIGH 12'h010

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SEM_BIT_FRAME_ERROR 12
`define SEM_BIT_ACTIVITY 11
`define SEM_BIT_UNDERRUN 8
`define SEM_BIT_SHIFTER_EMPTY 7
`define SEM_BIT_OVERFLOW 6
`define SEM_BIT_RX_EMPTY 5
`define SEM_BIT_TX_EMPTY 3
`define SEM_BIT_TX_FULL 1
`define SEM_BIT_RX_FULL 0
`define SEM_BIT_RX_WM_ENABLE 15
`define SEM_BIT_TX_WM_ENABLE 7
`define SEM_ENABLE_LOW_MASK 16'h19EB
`define SEM_WATERMARK_MASK 16'hBFBF

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define SEM_RESET_ENABLE_LOW 16'h0000
`define SEM_RESET_WATERMARK 16'h0000
`define SEM_RESET_BAUD 16'h0000
`define SEM_BUFFER_DEPTH 6'h20

`endif

// file: hw/sem_pkg.sv
package sem_pkg;
  // Phases of an APB transfer as seen by the slave.
  typedef enum logic [1:0] {
    SEM_IDLE = 2'b01,
    SEM_DONE = 2'b10
  } sem_phase_type;
  typedef logic [5:0] sem_level_type;
endpackage : sem_pkg

// file: hw/sem_watermark.sv
`timescale 1ns/1ps
`default_nettype none
module sem_watermark
  import sem_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire sem_level_type rx_level,
  input wire sem_level_type tx_level,
  input wire sem_level_type rx_count,
  input wire sem_level_type tx_count,
  output logic hit_q
);
  `include "sem_regs.svh"

  logic hit_d;

  // A level is usable only if it does not exceed the buffer depth.
  function automatic logic sem_level_ok(input sem_level_type level);
    sem_level_ok = (level <= `SEM_BUFFER_DEPTH);
  endfunction : sem_level_ok

  // Receive compares at-or-above, transmit needs an exact match.
  always_comb begin
    hit_d = 1'b0;
    if (rx_enable && sem_level_ok(rx_level) && (rx_level <= rx_count)) begin
      hit_d = 1'b1;
    end
    if (tx_enable && sem_level_ok(tx_level) && (tx_level == tx_count)) begin
      hit_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end
endmodule : sem_watermark
`default_nettype wire

// file: hw/sem_baud.sv
`timescale 1ns/1ps
`default_nettype none
module sem_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] divider,
  output logic sck_q
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic sck_d;

  // Toggle every divider+1 cycles, so the period is 2*(divider+1) bus clocks.
  always_comb begin
    cnt_d = cnt_q + 16'h0001;
    sck_d = sck_q;
    if (cnt_q >= divider) begin
      cnt_d = 16'h0000;
      sck_d = ~sck_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      sck_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sck_q <= sck_d;
    end
  end
endmodule : sem_baud
`default_nettype wire

// file: hw/sem_top.sv
`timescale 1ns/1ps
`default_nettype none
module sem_top
  import sem_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_error_flag,
  input wire logic activity_flag,
  input wire logic underrun_flag,
  input wire logic word_received,
  input wire logic rx_read,
  input wire logic tx_pending,
  input wire logic shifter_loaded,
  input wire logic [5:0] rx_element_count,
  input wire logic [5:0] tx_element_count,
  output logic overflow_flag,
  output logic shifter_empty_flag,
  output logic serial_clock,
  output logic event_request
);
  `include "sem_regs.svh"

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] enable_low_q, enable_low_d;
  logic [15:0] watermark_q, watermark_d;
  logic [15:0] baud_divider_q, baud_divider_d;
  logic overflow_q, overflow_d;
  logic shifter_empty_q, shifter_empty_d;
  logic event_q, event_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  sem_phase_type phase_q, phase_d;
  logic wm_hit;
  logic sck;
  logic [15:0] status_low;
  logic [15:0] status_high;
  logic [15:0] events;
  logic rx_empty, rx_full, tx_empty, tx_full;
  logic hit;

  // Derived buffer conditions from the element counts.
  assign rx_empty = (rx_element_count == 6'h00);
  assign tx_empty = (tx_element_count == 6'h00);
  assign rx_full = (rx_element_count >= `SEM_BUFFER_DEPTH);
  assign tx_full = (tx_element_count >= `SEM_BUFFER_DEPTH);

  // Status words as software sees them.
  always_comb begin
    status_low = 16'h0000;
    status_low[`SEM_BIT_FRAME_ERROR] = frame_error_flag;
    status_low[`SEM_BIT_ACTIVITY] = activity_flag;
    status_low[`SEM_BIT_UNDERRUN] = underrun_flag;
    status_low[`SEM_BIT_SHIFTER_EMPTY] = shifter_empty_q;
    status_low[`SEM_BIT_OVERFLOW] = overflow_q;
    status_low[`SEM_BIT_RX_EMPTY] = rx_empty;
    status_low[`SEM_BIT_TX_EMPTY] = tx_empty;
    status_low[`SEM_BIT_TX_FULL] = tx_full;
    status_low[`SEM_BIT_RX_FULL] = rx_full;
    status_high = {2'b00, rx_element_count, 2'b00, tx_element_count};
  end

  // Gate each status condition with its enable; bit positions line up 1:1.
  assign events = status_low & enable_low_q;

  // ------------------------------------------------------------
  // Status flags held in this block
  // ------------------------------------------------------------
  // Overflow is sticky; a new overflow in the clearing cycle wins.
  always_comb begin
    overflow_d = overflow_q;
    shifter_empty_d = !tx_pending && !shifter_loaded;
    if (psel && penable && pwrite && !pready_q && (paddr == `SEM_OFS_STATUS_LOW)
        && pwdata[`SEM_BIT_OVERFLOW]) begin
      overflow_d = 1'b0;
    end
    if (word_received && rx_full) begin
      overflow_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
      shifter_empty_q <= 1'b1;
    end else begin
      overflow_q <= overflow_d;
      shifter_empty_q <= shifter_empty_d;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait state: the access phase is answered at its second edge so that
  // read data comes straight from a flip-flop.
  always_comb begin
    phase_d = SEM_IDLE;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    enable_low_d = enable_low_q;
    watermark_d = watermark_q;
    baud_divider_d = baud_divider_q;
    if (psel && penable && (phase_q == SEM_IDLE)) begin
      phase_d = SEM_DONE;
      pready_d = 1'b1;
      prdata_d = 32'h00000000;
      unique case (paddr)
        `SEM_OFS_ENABLE_LOW: begin
          prdata_d = {16'h0000, enable_low_q};
          if (pwrite) begin
            enable_low_d = pwdata[15:0] & `SEM_ENABLE_LOW_MASK;
          end
        end
        `SEM_OFS_WATERMARK_HIGH: begin
          prdata_d = {16'h0000, watermark_q};
          if (pwrite) begin
            watermark_d = pwdata[15:0] & `SEM_WATERMARK_MASK;
          end
        end
        `SEM_OFS_BAUD_DIVIDER: begin
          prdata_d = {16'h0000, baud_divider_q};
          if (pwrite) begin
            baud_divider_d = pwdata[15:0];
          end
        end
        `SEM_OFS_STATUS_LOW: begin
          prdata_d = {16'h0000, status_low};
        end
        `SEM_OFS_STATUS_HIGH: begin
          prdata_d = {16'h0000, status_high};
        end
        default: begin
          pslverr_d = 1'b1; // Unmapped addresses answer with an error.
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= SEM_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      enable_low_q <= `SEM_RESET_ENABLE_LOW;
      watermark_q <= `SEM_RESET_WATERMARK;
      baud_divider_q <= `SEM_RESET_BAUD;
    end else begin
      phase_q <= phase_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      enable_low_q <= enable_low_d;
      watermark_q <= watermark_d;
      baud_divider_q <= baud_divider_d;
    end
  end

  // ------------------------------------------------------------
  // Watermarks, baud clock and request line
  // ------------------------------------------------------------
  sem_watermark u_watermark (
    .pclk(pclk),
    .presetn(presetn),
    .rx_enable(watermark_q[`SEM_BIT_RX_WM_ENABLE]),
    .tx_enable(watermark_q[`SEM_BIT_TX_WM_ENABLE]),
    .rx_level(watermark_q[13:8]),
    .tx_level(watermark_q[5:0]),
    .rx_count(rx_element_count),
    .tx_count(tx_element_count),
    .hit_q(wm_hit)
  );

  sem_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divider(baud_divider_q),
    .sck_q(sck)
  );

  // The request is a level, registered so it never glitches.
  assign hit = (|events) || wm_hit;
  always_comb begin
    event_d = hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_flag = overflow_q;
  assign shifter_empty_flag = shifter_empty_q;
  assign serial_clock = sck;
  assign event_request = event_q;
endmodule : sem_top
`default_nettype wire

// file: test/sem_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module sem_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic word_received,
  input wire logic [5:0] rx_element_count,
  input wire logic tx_pending,
  input wire logic shifter_loaded,
  input wire logic overflow_flag,
  input wire logic shifter_empty_flag
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_follows_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable)) else $error("stray ready");
  shifter_idle_a: assert property (!tx_pending && !shifter_loaded |=> shifter_empty_flag)
    else $error("empty shifter not shown");
  shifter_busy_a: assert property (tx_pending || shifter_loaded |=> !shifter_empty_flag)
    else $error("busy shifter shown empty");
  overflow_set_a: assert property (word_received && rx_element_count >= 6'h20 |=> overflow_flag)
    else $error("overflow missed");
  overflow_hold_a: assert property (overflow_flag && !(psel && paddr == 12'h00C) |=> overflow_flag)
    else $error("overflow lost");
  overflow_cause_a: assert property ($rose(overflow_flag) |-> $past(word_received))
    else $error("overflow without word");
endmodule : sem_top_properties
bind sem_top sem_top_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .word_received(word_received), .rx_element_count(rx_element_count),
  .tx_pending(tx_pending), .shifter_loaded(shifter_loaded), .overflow_flag(overflow_flag),
  .shifter_empty_flag(shifter_empty_flag));
`default_nettype wire

// file: test/sem_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial engine stand-in
// ----------------------------------------
module sem_engine_model (
  input wire logic [3:0] sel,
  input wire logic [5:0] rx_n,
  input wire logic [5:0] tx_n,
  output logic fe,
  output logic af,
  output logic uf,
  output logic wr,
  output logic tp,
  output logic sl,
  output logic [5:0] rc,
  output logic [5:0] tc
);
  // One condition at a time, except that overflow comes with a full receive buffer, so every enabled request has a single cause.
  always_comb begin
    fe = sel == 4'h1;
    af = sel == 4'h2;
    uf = sel == 4'h3;
    tp = sel != 4'h4;
    sl = sel != 4'h4;
    wr = sel == 4'h5;
    rc = (sel == 4'h5 || sel == 4'h9) ? 6'h20 : (sel == 4'h6) ? 6'h00 : rx_n;
    tc = (sel == 4'h8) ? 6'h20 : (sel == 4'h7) ? 6'h00 : tx_n;
  end
endmodule : sem_engine_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register and event bench
// ----------------------------------------
module tb;
  import sem_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, fe, af, uf, wr, tp, sl, ov, se, sk, ev;
  logic [5:0] rc, tc, rx_n = 6'h01, tx_n = 6'h01;
  logic [3:0] sel = 4'h0;
  int bad_count = 0, comparisons = 0;
  int bits [9] = '{12, 11, 8, 7, 6, 5, 3, 1, 0};
  // Cases: register value, expected request at bit 15, receive count, transmit count.
  logic [31:0] wm [9] = '{32'h8500_0401, 32'h8500_8501, 32'h8500_8601, 32'h0085_0104, 32'h0085_8105,
    32'h0085_0106, 32'h00A8_0128, 32'hA800_3F01, 32'h0500_0901};
  always #4 pclk = ~pclk;
  sem_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_error_flag(fe), .activity_flag(af), .underrun_flag(uf), .word_received(wr), .rx_read(1'b0),
    .tx_pending(tp), .shifter_loaded(sl), .rx_element_count(rc), .tx_element_count(tc),
    .overflow_flag(ov), .shifter_empty_flag(se), .serial_clock(sk), .event_request(ev));
  sem_engine_model u_eng (.sel(sel), .rx_n(rx_n), .tx_n(tx_n), .fe(fe), .af(af), .uf(uf), .wr(wr),
    .tp(tp), .sl(sl), .rc(rc), .tc(tc));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Holds the whole request until pready is seen at an edge, then idles one cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", rd, e);
  endtask : rchk
  // Measures the serial clock period in bus clocks between two rises.
  task automatic baud(input int dv);
    int c, w;
    logic p;
    c = 0;
    w = 0;
    p = 1'b1;
    apb(1'b1, 12'h008, 32'(dv));
    repeat (64) begin
      @(posedge pclk);
      if (sk === 1'b1 && p === 1'b0) begin
        w++;
        if (w == 2) chk("baud", 32'(c), 32'(2 * (dv + 1)));
        c = 0;
      end
      c++;
      p = sk;
    end
  endtask : baud
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // A hung handshake must not stall the run.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    rchk(12'h000, 32'h0000_19EB);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    rchk(12'h004, 32'h0000_BFBF);
    rchk(12'h014, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, 12'h000, 32'h1 << bits[k]);
      chk("idle", {31'h0, ev}, 32'h0);
      sel <= 4'(k + 1);
      repeat (3) @(posedge pclk);
      chk("raised", {31'h0, ev}, 32'h1);
      if (k == 3) chk("shifter empty", {31'h0, se}, 32'h1);
      if (k == 4) chk("overflow", {31'h0, ov}, 32'h1);
      rchk(12'h00C, (32'h1 << bits[k]) | {31'h0, k == 4});
      apb(1'b1, 12'h000, 32'h0);
      chk("masked", {31'h0, ev}, 32'h0);
      sel <= 4'h0;
      if (k == 4) apb(1'b1, 12'h00C, 32'h40);
    end
    chk("overflow cleared", {31'h0, ov}, 32'h0);
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, 12'h004, {16'h0, wm[k][31:16]});
      rx_n <= wm[k][13:8];
      tx_n <= wm[k][5:0];
      repeat (4) @(posedge pclk);
      chk("watermark", {31'h0, ev}, {31'h0, wm[k][15]});
      rchk(12'h010, {18'h0, wm[k][13:8], 2'h0, wm[k][5:0]});
    end
    baud(0);
    baud(3);
    rchk(12'h008, 32'h0000_0003);
    // A reset in mid-run must bring every writable register back to zero.
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset request", {31'h0, ev}, 32'h0);
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    rchk(12'h008, 32'h0);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
